// File: flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module flash_model (
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic flash_req,
  input  wire logic fail_next,
  input  wire logic slow,
  output logic      flash_done,
  output logic      flash_ok
);
  logic [5:0] wait_ff;
  logic       done_ff;
  logic       ok_ff;
  // The ok line toggles outside the done pulse, so a late or early sample fails.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      wait_ff <= 6'h00;
      done_ff <= 1'b0;
      ok_ff   <= 1'b0;
    end else begin
      done_ff <= (wait_ff == 6'h01);
      ok_ff   <= (wait_ff == 6'h01) ? !fail_next : !ok_ff;
      if (flash_req) wait_ff <= slow ? 6'h28 : 6'h02;
      else if (wait_ff != 6'h00) wait_ff <= wait_ff - 6'h01;
    end
  end
  assign flash_done = done_ff;
  assign flash_ok   = ok_ff;
endmodule
`default_nettype wire

// File: line_collect.sv
`timescale 1ns/1ps
`default_nettype none

module line_collect (
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic [7:0] rx_data,
  input  wire logic       rx_valid,
  line_if.src             ln
);
  import svc_pkg::*;

  logic             done_ff;
  logic [7:0]       c0_ff;
  logic [7:0]       c1_ff;
  logic [7:0]       c2_ff;
  logic [LEN_W-1:0] cnt_ff;
  logic [LEN_W-1:0] len_ff;

  wire is_cr   = rx_valid && (rx_data == CH_CR);
  wire is_char = rx_valid && (rx_data != CH_CR) && (rx_data != CH_LF);

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      done_ff <= 1'b0;
      c0_ff   <= 8'h00;
      c1_ff   <= 8'h00;
      c2_ff   <= 8'h00;
      cnt_ff  <= '0;
      len_ff  <= '0;
    end else begin
      done_ff <= is_cr;
      if (is_cr) begin
        len_ff <= cnt_ff;
        cnt_ff <= '0;
      end else if (is_char) begin
        if (cnt_ff == 4'h0) c0_ff <= rx_data;
        if (cnt_ff == 4'h1) c1_ff <= rx_data;
        if (cnt_ff == 4'h2) c2_ff <= rx_data;
        // Saturating, so an overlong line still counts as too many parameters.
        if (cnt_ff != LEN_MAX) cnt_ff <= cnt_ff + 4'h1;
      end
    end
  end

  assign ln.done = done_ff;
  assign ln.cmd  = c0_ff;
  assign ln.sep  = c1_ff;
  assign ln.arg  = c2_ff;
  assign ln.len  = len_ff;

endmodule

`default_nettype wire

// File: line_if.sv
`timescale 1ns/1ps
`default_nettype none

interface line_if;
  logic                          done;
  logic [7:0]                    cmd;
  logic [7:0]                    sep;
  logic [7:0]                    arg;
  logic [svc_pkg::LEN_W-1:0]     len;

  modport src (output done, output cmd, output sep, output arg, output len);
  modport dst (input done, input cmd, input sep, input arg, input len);
endinterface

`default_nettype wire

// File: svc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module svc_checker #(
  parameter int unsigned HOLD_CYCLES = 20,
  parameter int          CNT_W       = 16
) (
  input wire logic             mclk,
  input wire logic             rstn,
  input wire logic             resp_valid,
  input wire svc_pkg::resp_t   resp_code,
  input wire logic [CNT_W-1:0] save_count,
  input wire logic             flash_req,
  input wire logic             flash_src_factory,
  input wire logic             load_factory,
  input wire logic             load_flash,
  input wire logic             flash_done,
  input wire logic             flash_ok,
  input wire logic             go_normal,
  input wire logic             go_init
);
  import svc_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  wire ok_rsp = resp_valid && resp_code == RSP_SAVE_OK;
  wire bad_rsp = resp_valid && resp_code == RSP_E005;
  init_reload_a: assert property (go_init |-> load_flash)
    else $error("init exit without reload");
  one_target_a: assert property (go_normal |-> !go_init ##1 !go_normal)
    else $error("exit targets clash");
  factory_save_a: assert property (flash_req && flash_src_factory |-> load_factory)
    else $error("factory save without load");
  announce_normal_a: assert property (go_normal |-> resp_code == RSP_TO_NORMAL)
    else $error("normal exit not announced");
  announce_init_a: assert property (go_init |-> resp_code == RSP_TO_INIT)
    else $error("init exit not announced");
  save_count_a: assert property (ok_rsp |-> save_count == $past(save_count) + 1'b1)
    else $error("save count not advanced");
  count_hold_a: assert property ($changed(save_count) |-> resp_valid)
    else $error("save count moved silently");
  wear_warn_a: assert property (ok_rsp && save_count > SAVE_LIMIT
    |=> resp_valid && resp_code == RSP_E004)
    else $error("wear warning missing");
  flash_good_a: assert property (ok_rsp |-> $past(flash_done) && $past(flash_ok))
    else $error("success without flash done");
  flash_bad_a: assert property (bad_rsp |-> $past(flash_done) && !$past(flash_ok))
    else $error("save error without failure");
  cover property (resp_valid && resp_code == RSP_E004);
  cover property (go_init);
  cover property (flash_req && flash_src_factory);
endmodule
bind svc_cmd_unit svc_checker #(.HOLD_CYCLES(HOLD_CYCLES), .CNT_W(CNT_W)) chk_i (
  .mclk, .rstn, .resp_valid, .resp_code, .save_count, .flash_req, .flash_src_factory,
  .load_factory, .load_flash, .flash_done, .flash_ok, .go_normal, .go_init);
`default_nettype wire

// File: svc_cmd_unit.sv
`timescale 1ns/1ps
`default_nettype none

module svc_cmd_unit #(
  parameter int unsigned HOLD_CYCLES = svc_pkg::HOLD_CYCLES,
  parameter int          CNT_W       = svc_pkg::CNT_W
) (
  input  wire logic               mclk,
  input  wire logic               rstn,
  input  wire logic [7:0]         rx_data,
  input  wire logic               rx_valid,
  input  wire logic               cfg_dirty,
  input  wire logic               flash_done,
  input  wire logic               flash_ok,
  output logic                    resp_valid,
  output svc_pkg::resp_t          resp_code,
  output logic [CNT_W-1:0]        save_count,
  output logic                    flash_req,
  output logic                    flash_src_factory,
  output logic                    load_factory,
  output logic                    load_flash,
  output logic                    go_normal,
  output logic                    go_init,
  output logic                    busy
);
  import svc_pkg::*;

  line_if ln ();

  line_collect u_line (
    .mclk     (mclk),
    .rstn     (rstn),
    .rx_data  (rx_data),
    .rx_valid (rx_valid),
    .ln       (ln.src)
  );

  state_t           state_ff;
  state_t           nxt_state;
  resp_t            resp_ff;
  resp_t            nxt_resp;
  logic             resp_v_ff;
  logic             nxt_resp_v;
  resp_t            pend_ff;
  resp_t            nxt_pend;
  logic             pend_v_ff;
  logic             nxt_pend_v;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic             freq_ff;
  logic             nxt_freq;
  logic             fsrc_ff;
  logic             nxt_fsrc;
  logic             lfac_ff;
  logic             nxt_lfac;
  logic             lfl_ff;
  logic             nxt_lfl;
  logic             gon_ff;
  logic             nxt_gon;
  logic             goi_ff;
  logic             nxt_goi;
  logic             to_init_ff;
  logic             nxt_to_init;
  logic [31:0]      hold_ff;
  logic [31:0]      nxt_hold;

  // Decoding of the finished line.
  wire line_bare  = (ln.len == LEN_BARE);
  wire line_opt   = (ln.len == LEN_OPT);
  wire sep_ok     = (ln.sep == CH_SP);
  wire ans_yes    = line_bare && (ln.cmd == CH_UP_Y);
  wire ans_no     = line_bare && (ln.cmd == CH_UP_N);
  wire arg_lo_n   = (ln.arg == CH_LO_N);
  wire arg_lo_i   = (ln.arg == CH_LO_I);
  wire arg_up_n   = (ln.arg == CH_UP_N);
  wire arg_up_i   = (ln.arg == CH_UP_I);
  wire arg_slow   = arg_lo_n || arg_lo_i;
  wire arg_fast   = arg_up_n || arg_up_i;
  wire arg_init   = arg_lo_i || arg_up_i;
  wire [CNT_W-1:0] cnt_inc = cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
  wire over_limit = (cnt_inc > CNT_W'(SAVE_LIMIT));
  wire hold_end   = (hold_ff >= HOLD_CYCLES - 32'h0000_0001);

  function automatic resp_t announce(input logic to_init);
    announce = to_init ? RSP_TO_INIT : RSP_TO_NORMAL;
  endfunction

  always_comb begin
    nxt_state   = state_ff;
    nxt_resp    = resp_ff;
    nxt_resp_v  = 1'b0;
    nxt_pend    = pend_ff;
    nxt_pend_v  = pend_v_ff;
    nxt_cnt     = cnt_ff;
    nxt_freq    = 1'b0;
    nxt_fsrc    = fsrc_ff;
    nxt_lfac    = 1'b0;
    nxt_lfl     = 1'b0;
    nxt_gon     = 1'b0;
    nxt_goi     = 1'b0;
    nxt_to_init = to_init_ff;
    nxt_hold    = hold_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (ln.done) begin
          nxt_resp_v = 1'b1;
          nxt_state  = ST_PROMPT;
          if (ln.len == 4'h0) begin
            nxt_resp_v = 1'b0;
          end else if (ln.cmd == CH_SAVE) begin
            if (line_bare) begin
              nxt_resp  = RSP_SAVE_CONFIRM;
              nxt_state = ST_SAVE_ASK;
            end else begin
              nxt_resp = RSP_E002;
            end
          end else if (ln.cmd == CH_EXIT) begin
            if (!line_opt || !sep_ok) begin
              nxt_resp = RSP_E002;
            end else if (arg_fast) begin
              nxt_to_init = arg_init;
              nxt_resp    = announce(arg_init);
              nxt_state   = ST_LEAVE;
            end else if (arg_slow) begin
              nxt_to_init = arg_init;
              nxt_hold    = 32'h0000_0000;
              if (cfg_dirty) begin
                nxt_resp  = RSP_EXIT_CONFIRM;
                nxt_state = ST_EXIT_ASK;
              end else begin
                nxt_resp  = announce(arg_init);
                nxt_state = ST_HOLD;
              end
            end else begin
              nxt_resp = RSP_E003;
            end
          end else if (ln.cmd == CH_REST) begin
            if (line_bare) begin
              // Working copy only; it stays volatile until a save.
              nxt_lfac = 1'b1;
              nxt_resp = RSP_FACTORY_DONE;
            end else if (line_opt && sep_ok && (ln.arg == CH_LO_S)) begin
              nxt_lfac   = 1'b1;
              nxt_freq   = 1'b1;
              nxt_fsrc   = 1'b1;
              nxt_resp_v = 1'b0;
              nxt_state  = ST_FLASH;
            end else if (line_opt && sep_ok) begin
              nxt_resp = RSP_E003;
            end else begin
              nxt_resp = RSP_E002;
            end
          end else begin
            nxt_resp = RSP_E001;
          end
        end
      end
      ST_PROMPT: begin
        nxt_resp_v = 1'b1;
        if (pend_v_ff) begin
          nxt_resp   = pend_ff;
          nxt_pend_v = 1'b0;
        end else begin
          nxt_resp  = RSP_PROMPT;
          nxt_state = ST_IDLE;
        end
      end
      ST_SAVE_ASK: begin
        if (ln.done) begin
          if (ans_yes) begin
            // The counter is never consulted before writing.
            nxt_freq  = 1'b1;
            nxt_fsrc  = 1'b0;
            nxt_state = ST_FLASH;
          end else begin
            nxt_resp_v = 1'b1;
            nxt_resp   = RSP_SAVE_ABORTED;
            nxt_pend   = RSP_E003;
            nxt_pend_v = !ans_no;
            nxt_state  = ST_PROMPT;
          end
        end
      end
      ST_FLASH: begin
        if (flash_done) begin
          nxt_resp_v = 1'b1;
          nxt_state  = ST_PROMPT;
          if (flash_ok) begin
            nxt_cnt    = cnt_inc;
            nxt_resp   = fsrc_ff ? RSP_FACTORY_SAVED : RSP_SAVE_OK;
            nxt_pend   = RSP_E004;
            nxt_pend_v = over_limit;
          end else begin
            nxt_resp = RSP_E005;
          end
        end
      end
      ST_EXIT_ASK: begin
        if (ln.done) begin
          nxt_resp_v = 1'b1;
          if (ans_yes) begin
            nxt_resp  = announce(to_init_ff);
            nxt_state = ST_HOLD;
          end else if (ans_no) begin
            nxt_resp  = RSP_PROMPT;
            nxt_state = ST_IDLE;
          end else begin
            nxt_resp  = RSP_E003;
            nxt_state = ST_PROMPT;
          end
        end
      end
      ST_HOLD: begin
        nxt_hold = hold_ff + 32'h0000_0001;
        if (hold_end) nxt_state = ST_LEAVE;
      end
      ST_LEAVE: begin
        nxt_gon   = !to_init_ff;
        nxt_goi   = to_init_ff;
        // On an init exit, unsaved working changes are dropped in favour of the flash copy.
        nxt_lfl   = to_init_ff;
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_ff   <= ST_IDLE;
      resp_ff    <= RSP_PROMPT;
      resp_v_ff  <= 1'b0;
      pend_ff    <= RSP_PROMPT;
      pend_v_ff  <= 1'b0;
      cnt_ff     <= '0;
      freq_ff    <= 1'b0;
      fsrc_ff    <= 1'b0;
      lfac_ff    <= 1'b0;
      lfl_ff     <= 1'b0;
      gon_ff     <= 1'b0;
      goi_ff     <= 1'b0;
      to_init_ff <= 1'b0;
      hold_ff    <= 32'h0000_0000;
    end else begin
      state_ff   <= nxt_state;
      resp_ff    <= nxt_resp;
      resp_v_ff  <= nxt_resp_v;
      pend_ff    <= nxt_pend;
      pend_v_ff  <= nxt_pend_v;
      cnt_ff     <= nxt_cnt;
      freq_ff    <= nxt_freq;
      fsrc_ff    <= nxt_fsrc;
      lfac_ff    <= nxt_lfac;
      lfl_ff     <= nxt_lfl;
      gon_ff     <= nxt_gon;
      goi_ff     <= nxt_goi;
      to_init_ff <= nxt_to_init;
      hold_ff    <= nxt_hold;
    end
  end

  logic busy_ff;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= (nxt_state != ST_IDLE);
    end
  end

  assign resp_valid        = resp_v_ff;
  assign resp_code         = resp_ff;
  assign save_count        = cnt_ff;
  assign flash_req         = freq_ff;
  assign flash_src_factory = fsrc_ff;
  assign load_factory      = lfac_ff;
  assign load_flash        = lfl_ff;
  assign go_normal         = gon_ff;
  assign go_init           = goi_ff;
  assign busy              = busy_ff;

endmodule

`default_nettype wire

// File: svc_pkg.sv
package svc_pkg;

  // Characters seen on the command line.
  localparam logic [7:0] CH_CR    = 8'h0D;
  localparam logic [7:0] CH_LF    = 8'h0A;
  localparam logic [7:0] CH_SP    = 8'h20;
  localparam logic [7:0] CH_SAVE  = 8'h73;
  localparam logic [7:0] CH_EXIT  = 8'h78;
  localparam logic [7:0] CH_REST  = 8'h7A;
  localparam logic [7:0] CH_LO_N  = 8'h6E;
  localparam logic [7:0] CH_LO_I  = 8'h69;
  localparam logic [7:0] CH_UP_N  = 8'h4E;
  localparam logic [7:0] CH_UP_I  = 8'h49;
  localparam logic [7:0] CH_UP_Y  = 8'h59;
  localparam logic [7:0] CH_LO_S  = 8'h73;

  // Line length field and the lengths that the commands accept.
  localparam int         LEN_W      = 4;
  localparam logic [3:0] LEN_BARE   = 4'h1;
  localparam logic [3:0] LEN_OPT    = 4'h3;
  localparam logic [3:0] LEN_MAX    = 4'hF;

  // Save counter width and the rated number of flash saves.
  localparam int          CNT_W      = 16;
  localparam logic [15:0] SAVE_LIMIT = 16'h03E8;

  // Exit hold time, 3 s at 200 MHz.
  localparam int HOLD_TIME_MS = 3000;
  localparam int CLK_FREQ_KHZ = 200000;
  localparam int HOLD_CYCLES  = HOLD_TIME_MS * CLK_FREQ_KHZ;

  typedef enum logic [3:0] {
    RSP_PROMPT        = 4'h0,
    RSP_SAVE_CONFIRM  = 4'h1,
    RSP_SAVE_OK       = 4'h2,
    RSP_SAVE_ABORTED  = 4'h3,
    RSP_EXIT_CONFIRM  = 4'h4,
    RSP_TO_NORMAL     = 4'h5,
    RSP_TO_INIT       = 4'h6,
    RSP_FACTORY_DONE  = 4'h7,
    RSP_FACTORY_SAVED = 4'h8,
    RSP_E001          = 4'h9,
    RSP_E002          = 4'hA,
    RSP_E003          = 4'hB,
    RSP_E004          = 4'hC,
    RSP_E005          = 4'hD
  } resp_t;

  typedef enum logic [7:0] {
    ST_IDLE     = 8'h01,
    ST_PROMPT   = 8'h02,
    ST_SAVE_ASK = 8'h04,
    ST_FLASH    = 8'h08,
    ST_EXIT_ASK = 8'h10,
    ST_HOLD     = 8'h20,
    ST_LEAVE    = 8'h40
  } state_t;

endpackage

// File: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import svc_pkg::*;
  localparam int HOLD = 20;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  rx_data = 8'h00;
  logic        rx_valid = 1'b0;
  logic        cfg_dirty = 1'b0;
  logic        fail_next = 1'b0;
  logic        slow = 1'b0;
  logic        flash_done, flash_ok, resp_valid, flash_req, flash_src_factory;
  logic        load_factory, load_flash, go_normal, go_init, busy;
  resp_t       resp_code;
  logic [15:0] save_count;
  int          err_total, checks_done, cyc, ann_cyc, go_cyc, req_cnt, fact_cnt, saves;
  bit          go_seen, go_ini, go_lfl, req_fac;
  resp_t       rq[$];
  always #2.5 mclk = ~mclk;
  svc_cmd_unit #(.HOLD_CYCLES(HOLD)) dut (.mclk, .rstn, .rx_data, .rx_valid, .cfg_dirty,
    .flash_done, .flash_ok, .resp_valid, .resp_code, .save_count, .flash_req,
    .flash_src_factory, .load_factory, .load_flash, .go_normal, .go_init, .busy);
  flash_model flash_i (.mclk, .rstn, .flash_req, .fail_next, .slow, .flash_done, .flash_ok);
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (resp_valid === 1'b1) begin
      rq.push_back(resp_code);
      ann_cyc <= cyc;
    end
    if (flash_req === 1'b1) begin
      req_cnt <= req_cnt + 1;
      req_fac <= flash_src_factory;
    end
    if (load_factory === 1'b1) fact_cnt <= fact_cnt + 1;
    if ((go_normal | go_init) === 1'b1) begin
      go_seen <= 1'b1;
      go_ini <= go_init;
      go_lfl <= load_flash;
      go_cyc <= cyc;
    end
  end
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk_val(logic [31:0] got, logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t value %0h expected %0h", $time, got, exp);
    end
  endtask
  // Waits are bounded so a silent design ends the run instead of hanging it.
  task automatic chk_rsp(resp_t exp);
    int n;
    n = 0;
    while (rq.size() == 0 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    if (rq.size() == 0) begin
      err_total++;
      $display("[ERR] %0t no response", $time);
      final_report();
    end
    chk_val(rq.pop_front(), exp);
  endtask
  task automatic send(string s);
    for (int i = 0; i <= s.len(); i++) begin
      @(negedge mclk);
      rx_valid = 1'b1;
      rx_data = (i == s.len()) ? CH_CR : s[i];
    end
    @(negedge mclk);
    rx_valid = 1'b0;
  endtask
  task automatic t_seq(string s, resp_t e[$]);
    send(s);
    foreach (e[i]) chk_rsp(e[i]);
  endtask
  task automatic do_reset();
    @(negedge mclk);
    rstn = 1'b0;
    repeat (2) @(negedge mclk);
    rstn = 1'b1;
    rq.delete();
    go_seen = 1'b0;
  endtask
  task automatic t_save(bit bad);
    int r0;
    r0 = req_cnt;
    fail_next = bad;
    slow = bad;
    t_seq("s", '{RSP_SAVE_CONFIRM});
    chk_val(busy, 1);
    send("Y");
    if (bad) chk_rsp(RSP_E005);
    else begin
      saves++;
      chk_rsp(RSP_SAVE_OK);
      if (saves > 1000) chk_rsp(RSP_E004);
    end
    chk_rsp(RSP_PROMPT);
    chk_val(req_cnt - r0, 1);
    chk_val(save_count, saves);
    chk_val(req_fac, 0);
    chk_val(busy, 0);
    // Later flash users expect a fast, healthy flash again.
    fail_next = 1'b0;
    slow = 1'b0;
  endtask
  task automatic t_abort();
    int r0;
    r0 = req_cnt;
    t_seq("s", '{RSP_SAVE_CONFIRM});
    t_seq("N", '{RSP_SAVE_ABORTED, RSP_PROMPT});
    t_seq("s", '{RSP_SAVE_CONFIRM});
    t_seq("y", '{RSP_SAVE_ABORTED, RSP_E003, RSP_PROMPT});
    chk_val(req_cnt - r0, 0);
  endtask
  task automatic t_restore();
    int r0;
    int f0;
    r0 = req_cnt;
    f0 = fact_cnt;
    t_seq("z", '{RSP_FACTORY_DONE, RSP_PROMPT});
    chk_val(req_cnt - r0, 0);
    t_seq("z s", '{RSP_FACTORY_SAVED, RSP_PROMPT});
    saves++;
    chk_val(req_cnt - r0, 1);
    chk_val(req_fac, 1);
    chk_val(fact_cnt - f0, 2);
    chk_val(save_count, saves);
  endtask
  task automatic chk_go(bit ini, int lo);
    int n;
    n = 0;
    while (!go_seen && n < 100) begin
      @(negedge mclk);
      n++;
    end
    chk_val(go_seen, 1);
    if (!go_seen) final_report();
    chk_val(go_ini, ini);
    chk_val(go_lfl, ini);
    chk_val(go_cyc - ann_cyc >= lo && go_cyc - ann_cyc <= lo + 3, 1);
    chk_val(rq.size(), 0);
  endtask
  task automatic t_exit(string c, bit d, bit ini, int lo);
    do_reset();
    cfg_dirty = d;
    t_seq(c, '{ini ? RSP_TO_INIT : RSP_TO_NORMAL});
    chk_go(ini, lo);
  endtask
  task automatic t_exit_ask();
    do_reset();
    cfg_dirty = 1'b1;
    t_seq("x i", '{RSP_EXIT_CONFIRM});
    t_seq("N", '{RSP_PROMPT});
    t_seq("x n", '{RSP_EXIT_CONFIRM});
    t_seq("n", '{RSP_E003, RSP_PROMPT});
    chk_val(go_seen, 0);
    t_seq("x i", '{RSP_EXIT_CONFIRM});
    t_seq("Y", '{RSP_TO_INIT});
    chk_go(1, HOLD);
  endtask
  initial begin
    repeat (2) @(negedge mclk);
    rstn = 1'b1;
    t_seq("", '{RSP_PROMPT});
    t_seq("q", '{RSP_E001, RSP_PROMPT});
    t_seq("s1", '{RSP_E002, RSP_PROMPT});
    t_seq("x", '{RSP_E002, RSP_PROMPT});
    t_seq("x,n", '{RSP_E002, RSP_PROMPT});
    t_seq("x n 1", '{RSP_E002, RSP_PROMPT});
    t_seq("x q", '{RSP_E003, RSP_PROMPT});
    t_seq("z q", '{RSP_E003, RSP_PROMPT});
    t_save(0);
    t_save(1);
    t_abort();
    t_restore();
    while (saves < 1002) t_save(0);
    t_exit("x N", 1, 0, 1);
    t_exit("x I", 1, 1, 1);
    t_exit("x n", 0, 0, HOLD);
    t_exit("x i", 0, 1, HOLD);
    t_exit_ask();
    final_report();
  end
endmodule
`default_nettype wire
